// ===== verilog/fpk_pkg.sv
// Package with constants and types for the front panel key and mode controller.
package fpk_pkg;

  localparam int CLK_HZ = 100_000_000;
  localparam int MS_PER_S = 1000;
  // Times in their own units.
  localparam int BEEP_MS = 50;
  localparam int BLINK_MS = 100;
  localparam int REPEAT_MS = 250;
  localparam int BRIGHT_TIMEOUT_S = 5;
  localparam int WATER_SHOW_S = 5;
  localparam int MEASURE_S = 3;
  localparam int DEMO_STEP_MS = 1000;
  localparam int TICK_MS = 200;
  // Cycle count derived from the clock rate, and millisecond counts (one millisecond tick drives all timers).
  localparam int MS_CYCLES = CLK_HZ / MS_PER_S;
  localparam int BRIGHT_TIMEOUT_MS = BRIGHT_TIMEOUT_S * MS_PER_S;
  localparam int WATER_SHOW_MS = WATER_SHOW_S * MS_PER_S;
  localparam int MEASURE_MS = MEASURE_S * MS_PER_S;

  // Sensor: divided by 1024; counts of divided edges over a 3 s window.
  localparam int SENSOR_DIVIDE = 1024;
  localparam int HZ_MIDPOINT_LO = 39_500;
  localparam int HZ_MIDPOINT_HI = 40_500;
  localparam int HZ_NO_SIGNAL = 30_000;
  // Both edges of the divided wave are counted, so each input period gives 2/1024 events.
  localparam logic [15:0] CNT_MID_LO = 16'(HZ_MIDPOINT_LO * MEASURE_S * 2 / SENSOR_DIVIDE);
  localparam logic [15:0] CNT_MID_HI = 16'(HZ_MIDPOINT_HI * MEASURE_S * 2 / SENSOR_DIVIDE);
  localparam logic [15:0] CNT_NO_SIG = 16'(HZ_NO_SIGNAL * MEASURE_S * 2 / SENSOR_DIVIDE);

  // Value ranges and factory defaults.
  localparam logic [6:0] VALUE_MAX = 7'h63;
  localparam logic [6:0] VALUE_MIN = 7'h00;
  localparam logic [3:0] BRIGHT_MAX = 4'h8;
  localparam logic [3:0] BRIGHT_MIN = 4'h1;
  localparam logic [6:0] DEFAULT_VOLUME = 7'h00;
  localparam logic [6:0] DEFAULT_CHANNEL = 7'h00;
  localparam logic [3:0] DEFAULT_BRIGHT = 4'h8;
  localparam int KEY_COUNT = 8;

  typedef enum logic [1:0] {LEVEL_MID, LEVEL_LOW, LEVEL_HIGH, LEVEL_NONE} fpk_level_type;
  typedef enum logic [2:0] {SHOW_NORMAL, SHOW_BRIGHT, SHOW_DEMO_SAME, SHOW_DEMO_DIFF, SHOW_WATER} fpk_show_type;

  // The eight touch keys, one bit each.
  typedef struct packed {
    logic restore;
    logic water_level_key;
    logic demo;
    logic menu;
    logic channel_down_key;
    logic channel_up_key;
    logic volume_down_key;
    logic volume_up_key;
  } fpk_keys_type;

  // Panel state shown to the display driver.
  typedef struct packed {
    fpk_show_type show;
    logic [6:0] volume;
    logic [6:0] channel;
    logic [3:0] bright;
    logic [7:0] bright_leds;
    fpk_level_type level;
  } fpk_view_type;

endpackage

// ===== verilog/fpk_front_panel.sv
// Front panel key, mode, encoder and water level controller.
`timescale 1ns/1ps

module fpk_front_panel #(
  parameter int REPEAT_INTERVAL_MS = fpk_pkg::REPEAT_MS,
  parameter int MS_TICK_CYCLES = fpk_pkg::MS_CYCLES
) (
  // Clock and reset.
  input wire logic CLK,
  input wire logic RSTN,
  // Touch keys, level high while touched, from outside the clock domain.
  input wire fpk_pkg::fpk_keys_type KEYS,
  // Rotary encoder phases and water sensor wave.
  input wire logic ENC_A,
  input wire logic ENC_B,
  input wire logic SENSOR_WAVE,
  // Panel outputs.
  output fpk_pkg::fpk_view_type VIEW,
  output logic BUZZER,
  output logic TOUCH_LED,
  output logic WATER_ALARM
);
  import fpk_pkg::*;

  // Two-flop synchronisers for all asynchronous inputs.
  logic [10:0] sync1;
  logic [10:0] sync2;
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      sync1 <= '0;
      sync2 <= '0;
    end
    else
    begin
      sync1 <= {SENSOR_WAVE, ENC_B, ENC_A, KEYS};
      sync2 <= sync1;
    end
  end

  fpk_keys_type keys;
  logic enc_a;
  logic enc_b;
  logic wave;
  assign keys = fpk_keys_type'(sync2[7:0]);
  assign enc_a = sync2[8];
  assign enc_b = sync2[9];
  assign wave = sync2[10];

  function automatic logic [6:0] sat_up(input logic [6:0] v, input logic [6:0] top);
    sat_up = (v >= top) ? top : 7'(v + 7'h01);
  endfunction

  function automatic logic [6:0] sat_down(input logic [6:0] v, input logic [6:0] bottom);
    sat_down = (v <= bottom) ? bottom : 7'(v - 7'h01);
  endfunction

  // Millisecond tick, the time base of every timer.
  logic [16:0] ms_div;
  logic [16:0] next_ms_div;
  logic ms_tick;
  always_comb
  begin
    ms_tick = (ms_div == 17'(MS_TICK_CYCLES - 1));
    next_ms_div = ms_tick ? 17'h0_0000 : 17'(ms_div + 17'h0_0001);
  end

  // Key edges and held-key repeat.
  fpk_keys_type keys_prev;
  fpk_keys_type next_keys_prev;
  logic [15:0] rep_cnt;
  logic [15:0] next_rep_cnt;
  logic [7:0] press;
  logic any_press;
  logic step_vu;
  logic step_vd;
  logic step_cu;
  logic step_cd;
  logic repeat_fire;
  always_comb
  begin
    press = keys & ~keys_prev;
    any_press = |press;
    next_keys_prev = keys;
    repeat_fire = 1'b0;
    if (any_press || keys[3:0] == 4'h0)
      next_rep_cnt = 16'h0000;
    else if (ms_tick && rep_cnt == 16'(REPEAT_INTERVAL_MS - 1))
    begin
      next_rep_cnt = 16'h0000;
      repeat_fire = 1'b1;
    end
    else if (ms_tick)
      next_rep_cnt = 16'(rep_cnt + 16'h0001);
    else
      next_rep_cnt = rep_cnt;
    // A step on the touch and then once per repeat interval while still held.
    step_vu = press[0] | (repeat_fire & keys.volume_up_key);
    step_vd = press[1] | (repeat_fire & keys.volume_down_key);
    step_cu = press[2] | (repeat_fire & keys.channel_up_key);
    step_cd = press[3] | (repeat_fire & keys.channel_down_key);
  end

  // Encoder: the phases act as two key events; the level of B at each rising edge of A gives direction.
  logic enc_a_prev;
  logic enc_up;
  logic enc_down;
  always_comb
  begin
    enc_up = enc_a & ~enc_a_prev & ~enc_b;
    enc_down = enc_a & ~enc_a_prev & enc_b;
  end

  // Sensor: divide by 1024, each divided transition is one event counted in the window.
  logic wave_prev;
  logic [9:0] div_cnt;
  logic [9:0] next_div_cnt;
  logic div_out;
  logic next_div_out;
  logic sensor_event;
  logic [15:0] ev_cnt;
  logic [15:0] next_ev_cnt;
  logic [12:0] win_ms;
  logic [12:0] next_win_ms;
  fpk_level_type level;
  fpk_level_type next_level;
  always_comb
  begin
    next_div_cnt = div_cnt;
    next_div_out = div_out;
    sensor_event = 1'b0;
    if (wave & ~wave_prev)
    begin
      next_div_cnt = 10'(div_cnt + 10'h001);
      // Each half of the divided wave is 512 input periods long.
      if (div_cnt == 10'(SENSOR_DIVIDE / 2 - 1))
      begin
        next_div_cnt = 10'h000;
        next_div_out = ~div_out;
        sensor_event = 1'b1;
      end
    end
    // Each taken event adds one to the count of the current window.
    next_ev_cnt = sensor_event ? 16'(ev_cnt + 16'h0001) : ev_cnt;
    next_win_ms = win_ms;
    next_level = level;
    if (ms_tick)
    begin
      next_win_ms = 13'(win_ms + 13'h0001);
      if (win_ms == 13'(MEASURE_MS - 1))
      begin
        next_win_ms = 13'h0000;
        next_ev_cnt = sensor_event ? 16'h0001 : 16'h0000;
        if (ev_cnt < CNT_NO_SIG)
          next_level = LEVEL_NONE;
        else if (ev_cnt < CNT_MID_LO)
          next_level = LEVEL_LOW;
        else if (ev_cnt > CNT_MID_HI)
          next_level = LEVEL_HIGH;
        else
          next_level = LEVEL_MID;
      end
    end
  end

  // Mode machine and panel values.
  fpk_show_type show;
  fpk_show_type next_show;
  logic [6:0] volume;
  logic [6:0] next_volume;
  logic [6:0] channel;
  logic [6:0] next_channel;
  logic [3:0] bright;
  logic [3:0] next_bright;
  logic [12:0] mode_ms;
  logic [12:0] next_mode_ms;
  logic bright_up;
  logic bright_down;
  always_comb
  begin
    next_show = show;
    next_volume = volume;
    next_channel = channel;
    next_bright = bright;
    next_mode_ms = ms_tick ? 13'(mode_ms + 13'h0001) : mode_ms;
    bright_up = step_cu | enc_up;
    bright_down = step_cd | enc_down;
    case (show)
      SHOW_BRIGHT:
      begin
        if (bright_up)
          next_bright = 4'(sat_up({3'h0, bright}, {3'h0, BRIGHT_MAX}));
        else if (bright_down)
          next_bright = 4'(sat_down({3'h0, bright}, {3'h0, BRIGHT_MIN}));
        if (bright_up || bright_down)
          next_mode_ms = 13'h0000;
        if ((press & ~8'h0C) != 8'h00 || mode_ms == 13'(BRIGHT_TIMEOUT_MS))
          next_show = SHOW_NORMAL;
      end
      SHOW_DEMO_SAME, SHOW_DEMO_DIFF:
      begin
        if (mode_ms == 13'(DEMO_STEP_MS))
        begin
          next_mode_ms = 13'h0000;
          next_show = (show == SHOW_DEMO_SAME) ? SHOW_DEMO_DIFF : SHOW_DEMO_SAME;
        end
        if (any_press && !keys.demo)
          next_show = SHOW_NORMAL;
      end
      default:
      begin
        if (step_vu || enc_up)
          next_volume = sat_up(volume, VALUE_MAX);
        else if (step_vd || enc_down)
          next_volume = sat_down(volume, VALUE_MIN);
        if (step_cu)
          next_channel = (channel >= VALUE_MAX) ? VALUE_MIN : 7'(channel + 7'h01);
        else if (step_cd)
          next_channel = (channel == VALUE_MIN) ? VALUE_MAX : 7'(channel - 7'h01);
        if (show == SHOW_WATER && mode_ms == 13'(WATER_SHOW_MS))
          next_show = SHOW_NORMAL;
        if (press[4])
        begin
          next_show = SHOW_BRIGHT;
          next_mode_ms = 13'h0000;
        end
        else if (press[5])
        begin
          next_show = SHOW_DEMO_SAME;
          next_mode_ms = 13'h0000;
        end
        else if (press[6])
        begin
          next_show = SHOW_WATER;
          next_mode_ms = 13'h0000;
        end
        else if (press[7])
        begin
          next_volume = DEFAULT_VOLUME;
          next_channel = DEFAULT_CHANNEL;
          next_bright = DEFAULT_BRIGHT;
        end
      end
    endcase
  end

  // Beep and blink on each touch, tick alarm while away from midpoint.
  logic [7:0] beep_ms;
  logic [7:0] next_beep_ms;
  logic [7:0] tick_ms;
  logic [7:0] next_tick_ms;
  logic tick_phase;
  logic next_tick_phase;
  logic alarm;
  always_comb
  begin
    alarm = (level != LEVEL_MID);
    if (any_press)
      next_beep_ms = 8'(BLINK_MS);
    else if (ms_tick && beep_ms != 8'h00)
      next_beep_ms = 8'(beep_ms - 8'h01);
    else
      next_beep_ms = beep_ms;
    next_tick_ms = tick_ms;
    next_tick_phase = tick_phase;
    if (!alarm)
    begin
      next_tick_ms = 8'h00;
      next_tick_phase = 1'b0;
    end
    else if (ms_tick)
    begin
      next_tick_ms = 8'(tick_ms + 8'h01);
      if (tick_ms == 8'(TICK_MS - 1))
      begin
        next_tick_ms = 8'h00;
        next_tick_phase = ~tick_phase;
      end
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      ms_div <= '0;
      keys_prev <= '0;
      rep_cnt <= '0;
      enc_a_prev <= 1'b0;
      wave_prev <= 1'b0;
      div_cnt <= '0;
      div_out <= 1'b0;
      ev_cnt <= '0;
      win_ms <= '0;
      level <= LEVEL_MID;
      show <= SHOW_NORMAL;
      volume <= DEFAULT_VOLUME;
      channel <= DEFAULT_CHANNEL;
      bright <= DEFAULT_BRIGHT;
      mode_ms <= '0;
      beep_ms <= '0;
      tick_ms <= '0;
      tick_phase <= 1'b0;
    end
    else
    begin
      ms_div <= next_ms_div;
      keys_prev <= next_keys_prev;
      rep_cnt <= next_rep_cnt;
      enc_a_prev <= enc_a;
      wave_prev <= wave;
      div_cnt <= next_div_cnt;
      div_out <= next_div_out;
      ev_cnt <= next_ev_cnt;
      win_ms <= next_win_ms;
      level <= next_level;
      show <= next_show;
      volume <= next_volume;
      channel <= next_channel;
      bright <= next_bright;
      mode_ms <= next_mode_ms;
      beep_ms <= next_beep_ms;
      tick_ms <= next_tick_ms;
      tick_phase <= next_tick_phase;
    end
  end

  // Registered outputs; the level LED bar lights one LED per brightness level.
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      VIEW <= '0;
      BUZZER <= 1'b0;
      TOUCH_LED <= 1'b0;
      WATER_ALARM <= 1'b0;
    end
    else
    begin
      VIEW.show <= next_show;
      VIEW.volume <= next_volume;
      VIEW.channel <= next_channel;
      VIEW.bright <= next_bright;
      VIEW.bright_leds <= 8'((9'h001 << next_bright) - 9'h001);
      VIEW.level <= next_level;
      BUZZER <= (next_beep_ms > 8'(BLINK_MS - BEEP_MS)) | next_tick_phase;
      TOUCH_LED <= (next_beep_ms != 8'h00);
      WATER_ALARM <= (next_level != LEVEL_MID);
    end
  end

endmodule // fpk_front_panel

// ===== tb/fpk_front_panel_monitor.sv
// Checker for the front panel controller ports.
`timescale 1ns/1ps
module fpk_front_panel_monitor #(
  parameter int REPEAT_INTERVAL_MS = 2,
  parameter int MS_TICK_CYCLES = 10
) (
  // Clock and reset.
  input wire logic CLK,
  input wire logic RSTN,
  // Inputs of the block.
  input wire fpk_pkg::fpk_keys_type KEYS,
  input wire logic ENC_A,
  input wire logic ENC_B,
  input wire logic SENSOR_WAVE,
  // Outputs of the block.
  input wire fpk_pkg::fpk_view_type VIEW,
  input wire logic BUZZER,
  input wire logic TOUCH_LED,
  input wire logic WATER_ALARM
);
  import fpk_pkg::*;
  localparam int QUIET_MAX = 2 * TICK_MS * MS_TICK_CYCLES;
  int quiet;
  logic last_buzzer;
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RSTN);
  // Counts cycles of an unchanged buzzer while the alarm is on.
  always_ff @(posedge CLK)
  begin
    last_buzzer <= BUZZER;
    if (!RSTN || !WATER_ALARM || BUZZER != last_buzzer)
      quiet <= 0;
    else
      quiet <= quiet + 1;
  end
  property p_touch;
    |(KEYS & ~$past(KEYS)) |-> ##[1:5] TOUCH_LED;
  endproperty
  a_touch: assert property (p_touch) else $error("touch without blink");
  property p_beep;
    $rose(BUZZER) && !WATER_ALARM && !$past(WATER_ALARM) |-> TOUCH_LED;
  endproperty
  a_beep: assert property (p_beep) else $error("beep without touch");
  property p_vol;
    $changed(VIEW.volume) |-> VIEW.volume <= VALUE_MAX && (VIEW.volume == 7'($past(VIEW.volume) + 1)
      || VIEW.volume == 7'($past(VIEW.volume) - 1) || VIEW.volume == DEFAULT_VOLUME);
  endproperty
  a_vol: assert property (p_vol) else $error("volume jump");
  property p_chan;
    $changed(VIEW.channel) |-> VIEW.channel <= VALUE_MAX && (VIEW.channel == 7'($past(VIEW.channel) + 1)
      || VIEW.channel == 7'($past(VIEW.channel) - 1) || VIEW.channel == 7'h00 || VIEW.channel == VALUE_MAX);
  endproperty
  a_chan: assert property (p_chan) else $error("channel jump");
  property p_leds;
    $past(RSTN) |-> VIEW.bright inside {[BRIGHT_MIN:BRIGHT_MAX]}
      && VIEW.bright_leds == 8'(8'hFF >> (4'h8 - VIEW.bright));
  endproperty
  a_leds: assert property (p_leds) else $error("level leds wrong");
  property p_demo;
    (KEYS == '0) [*5] ##0 (VIEW.show == SHOW_DEMO_SAME || VIEW.show == SHOW_DEMO_DIFF)
      |=> (VIEW.show == SHOW_DEMO_SAME || VIEW.show == SHOW_DEMO_DIFF);
  endproperty
  a_demo: assert property (p_demo) else $error("demo left untouched");
  property p_restore;
    $rose(KEYS.restore) && KEYS[6:0] == 7'h00 && VIEW.show == SHOW_NORMAL |-> ##[3:5]
      (VIEW.volume == 7'h00 && VIEW.channel == 7'h00 && VIEW.bright == 4'h8);
  endproperty
  a_restore: assert property (p_restore) else $error("restore missed");
  property p_alarm;
    $changed(VIEW.level) |-> ##[0:1] WATER_ALARM == (VIEW.level != LEVEL_MID);
  endproperty
  a_alarm: assert property (p_alarm) else $error("alarm flag wrong");
  property p_tick;
    quiet < QUIET_MAX;
  endproperty
  a_tick: assert property (p_tick) else $error("alarm tick stopped");
  c_bright: cover property (VIEW.show == SHOW_BRIGHT);
  c_demo: cover property (VIEW.show == SHOW_DEMO_DIFF);
  c_alarm: cover property ($rose(WATER_ALARM));
endmodule // fpk_front_panel_monitor

bind fpk_front_panel fpk_front_panel_monitor #(
  .REPEAT_INTERVAL_MS(REPEAT_INTERVAL_MS),
  .MS_TICK_CYCLES(MS_TICK_CYCLES)
) fpk_front_panel_monitor_inst (
  .CLK(CLK), .RSTN(RSTN), .KEYS(KEYS), .ENC_A(ENC_A), .ENC_B(ENC_B), .SENSOR_WAVE(SENSOR_WAVE),
  .VIEW(VIEW), .BUZZER(BUZZER), .TOUCH_LED(TOUCH_LED), .WATER_ALARM(WATER_ALARM)
);

// ===== tb/fpk_panel_model.sv
// Model of the touch keys, rotary encoder and water level sensor.
`timescale 1ns/1ps
module fpk_panel_model (
  // Clock.
  input wire logic clk,
  // Panel inputs of the block.
  output fpk_pkg::fpk_keys_type keys,
  output logic enc_a,
  output logic enc_b,
  output logic sensor_wave
);
  import fpk_pkg::*;
  // Half period of the sensor wave in clock cycles; zero leaves the sensor silent.
  int sensor_half;
  int sensor_cnt;
  initial
  begin
    keys = '0;
    enc_a = 1'b0;
    enc_b = 1'b0;
    sensor_wave = 1'b0;
    sensor_half = 0;
    sensor_cnt = 0;
  end
  // Free-running sensor square wave, changed only just after a rising edge.
  always @(posedge clk)
  begin
    if (sensor_half == 0)
      sensor_cnt <= 0;
    else if (sensor_cnt >= sensor_half - 1)
    begin
      sensor_cnt <= 0;
      sensor_wave <= ~sensor_wave;
    end
    else
      sensor_cnt <= sensor_cnt + 1;
  end
  // Starts the sensor wave with the given half period in cycles.
  task automatic run_sensor(input int half);
    @(posedge clk);
    sensor_half <= half;
  endtask
  // Touches one key for a number of cycles; returns at a falling edge.
  task automatic touch(input int k, input int hold);
    @(posedge clk);
    keys[k] <= 1'b1;
    repeat (hold) @(posedge clk);
    keys[k] <= 1'b0;
    repeat (8) @(posedge clk);
    @(negedge clk);
  endtask
  // One detent: phase A rises with phase B low for up, high for down.
  task automatic turn(input logic down);
    @(posedge clk);
    enc_b <= down;
    repeat (3) @(posedge clk);
    enc_a <= ~enc_a;
    repeat (3) @(posedge clk);
    enc_b <= ~down;
    repeat (3) @(posedge clk);
    enc_a <= ~enc_a;
    repeat (3) @(posedge clk);
    enc_b <= 1'b0;
    repeat (8) @(posedge clk);
    @(negedge clk);
  endtask
endmodule // fpk_panel_model

// ===== tb/test_fpk_front_panel.sv
// Self-checking testbench for the front panel controller.
`timescale 1ns/1ps
module test_fpk_front_panel;
  import fpk_pkg::*;
  logic clk;
  logic rstn;
  fpk_keys_type keys;
  logic enc_a;
  logic enc_b;
  logic sensor_wave;
  fpk_view_type view;
  logic buzzer;
  logic touch_led;
  logic water_alarm;
  int n_checks;
  int n_fail;
  fpk_front_panel #(
    .REPEAT_INTERVAL_MS(2),
    .MS_TICK_CYCLES(10)
  ) fpk_front_panel_inst (
    .CLK(clk), .RSTN(rstn), .KEYS(keys), .ENC_A(enc_a), .ENC_B(enc_b), .SENSOR_WAVE(sensor_wave),
    .VIEW(view), .BUZZER(buzzer), .TOUCH_LED(touch_led), .WATER_ALARM(water_alarm)
  );
  fpk_panel_model fpk_panel_model_inst (
    .clk(clk), .keys(keys), .enc_a(enc_a), .enc_b(enc_b), .sensor_wave(sensor_wave)
  );
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_show(input fpk_show_type got, input fpk_show_type exp);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH at %0t: show %h expected %h", $time, got, exp);
    end
  endtask
  // Waits a bounded time for a display mode; a miss ends the run.
  task automatic wait_show(input fpk_show_type exp, input int bound);
    for (int i = 0; i < bound && view.show !== exp; i++)
      @(negedge clk);
    chk_show(view.show, exp);
    if (view.show !== exp)
      end_sim();
  endtask
  task automatic tap(input int k);
    fpk_panel_model_inst.touch(k, 3);
  endtask
  task automatic t_defaults();
    chk_show(view.show, SHOW_NORMAL);
    chk_val(8'(view.volume), 8'h00);
    chk_val(8'(view.channel), 8'h00);
    chk_val(8'(view.bright), 8'h08);
    chk_val(view.bright_leds, 8'hFF);
    chk_val(8'(view.level), 8'(LEVEL_MID));
    chk_val(8'(water_alarm), 8'h00);
  endtask
  task automatic t_volume();
    tap(1);
    chk_val(8'(touch_led), 8'h01);
    chk_val(8'(buzzer), 8'h01);
    chk_val(8'(view.volume), 8'h00);
    // The beep lasts 50 ms and the blink 100 ms, at 10 cycles per ms here.
    repeat (600) @(negedge clk);
    chk_val(8'(buzzer), 8'h00);
    chk_val(8'(touch_led), 8'h01);
    repeat (500) @(negedge clk);
    chk_val(8'(touch_led), 8'h00);
    fpk_panel_model_inst.touch(0, 2100);
    chk_val(8'(view.volume), 8'h63);
    tap(1);
    chk_val(8'(view.volume), 8'h62);
    fpk_panel_model_inst.touch(1, 2100);
    chk_val(8'(view.volume), 8'h00);
  endtask
  task automatic t_channel();
    tap(3);
    chk_val(8'(view.channel), 8'h63);
    tap(2);
    chk_val(8'(view.channel), 8'h00);
    tap(2);
    chk_val(8'(view.channel), 8'h01);
    fpk_panel_model_inst.turn(1'b0);
    fpk_panel_model_inst.turn(1'b0);
    chk_val(8'(view.volume), 8'h02);
    fpk_panel_model_inst.turn(1'b1);
    chk_val(8'(view.volume), 8'h01);
  endtask
  task automatic t_bright();
    tap(4);
    chk_show(view.show, SHOW_BRIGHT);
    tap(3);
    chk_val(view.bright_leds, 8'h7F);
    fpk_panel_model_inst.touch(3, 200);
    chk_val(8'(view.bright), 8'h01);
    fpk_panel_model_inst.turn(1'b0);
    chk_val(8'(view.bright), 8'h02);
    fpk_panel_model_inst.touch(2, 200);
    chk_val(8'(view.bright), 8'h08);
    tap(3);
    chk_val(8'(view.volume), 8'h01);
    repeat (48000) @(negedge clk);
    chk_show(view.show, SHOW_BRIGHT);
    wait_show(SHOW_NORMAL, 3000);
    chk_val(8'(view.bright), 8'h07);
    chk_val(8'(view.level), 8'(LEVEL_NONE));
    chk_val(8'(water_alarm), 8'h01);
    tap(4);
    tap(0);
    chk_show(view.show, SHOW_NORMAL);
    chk_val(8'(view.volume), 8'h01);
  endtask
  task automatic t_demo();
    tap(5);
    chk_show(view.show, SHOW_DEMO_SAME);
    wait_show(SHOW_DEMO_DIFF, 10100);
    wait_show(SHOW_DEMO_SAME, 10100);
    fpk_panel_model_inst.turn(1'b0);
    chk_show(view.show, SHOW_DEMO_SAME);
    tap(1);
    chk_show(view.show, SHOW_NORMAL);
    chk_val(8'(view.volume), 8'h01);
  endtask
  task automatic t_restore_water();
    tap(7);
    chk_val(8'(view.volume), 8'h00);
    chk_val(8'(view.channel), 8'h00);
    chk_val(8'(view.bright), 8'h08);
    tap(6);
    chk_show(view.show, SHOW_WATER);
    chk_val(8'(view.level), 8'(LEVEL_NONE));
  endtask
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial
  begin
    n_checks = 0;
    n_fail = 0;
    rstn = 1'b0;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    repeat (5) @(negedge clk);
    t_defaults();
    // A 4-cycle sensor period gives about 14 divided edges per window, far below the no-signal limit.
    fpk_panel_model_inst.run_sensor(2);
    t_volume();
    t_channel();
    t_bright();
    t_demo();
    t_restore_water();
    end_sim();
  end
endmodule // test_fpk_front_panel
